// ### pkg/blit_defines.vh
// register indices, field positions and codes for the host-fed blit data path
//
// Functional notes
// - all sixteen raster codes; 0Ch copies source
// - linear and rectangular destination addressing supported
// - 16 bpp: one word per pixel
// - 8 bpp phase one: first pixel high byte
// - 8 bpp phase zero: low byte then high
// - lone last pixel of line from low byte
// - 8 bpp word count from width, phase, height
// - every accepted word write in aperture counts once
// - write 80h starts; bit 7 reads one
// - full flag bit 4; host holds writes
// - operation 00h write blit; format 00h 8 bpp
// - both linear selects zero gives rectangle
// - line stride in words advances destination lines
// - expanded bit one foreground, zero background
// - expand low byte first, bit 7 downward
// - source bit 0 start byte, start bit position
// - start bit 7, width 16 expands whole word
// - width and height are 10-bit count minus one
// - 16-word fifo behind 1M aperture
// - colours 16 bits; 8 bpp uses bits 7-0
`ifndef BLIT_DEFINES_VH
`define BLIT_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_CTRL 9'h100
`define IDX_FORMAT 9'h101
`define IDX_ROP 9'h102
`define IDX_OPSEL 9'h103
`define IDX_SRC_LO 9'h104
`define IDX_DST_LO 9'h108
`define IDX_DST_MID 9'h109
`define IDX_DST_HI 9'h10a
`define IDX_STRIDE_LO 9'h10c
`define IDX_STRIDE_HI 9'h10d
`define IDX_WIDTH_LO 9'h110
`define IDX_WIDTH_HI 9'h111
`define IDX_HEIGHT_LO 9'h112
`define IDX_HEIGHT_HI 9'h113
`define IDX_BG_LO 9'h114
`define IDX_BG_HI 9'h115
`define IDX_FG_LO 9'h118
`define IDX_FG_HI 9'h119
`define IDX_LINEAR 9'h11c

// aperture select: byte address bit 20 high
`define APERTURE_BIT 20

// control register fields
`define CTRL_START_BIT 7
`define CTRL_NOT_EMPTY_BIT 6
`define CTRL_HALF_BIT 5
`define CTRL_FULL_BIT 4
// linear select register fields
`define LIN_DST_BIT 0
`define LIN_SRC_BIT 1

// codes
`define OP_WRITE_ROP 8'h00
`define OP_COLOR_EXPAND 8'h08
`define FMT_16BPP_BIT 0

// reset values
`define RST_BYTE 8'h00
`define RST_ROP 8'h0c

`endif

// ### rtl/word_fifo.v
// synchronous word fifo held in flip-flops, with occupancy count
module word_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH_LOG2 = 4
) (
    input wire ref_clk,
    input wire rstn,
    input wire wr_valid,
    output wire wr_ready,
    input wire [WIDTH-1:0] wr_data,
    output wire rd_valid,
    input wire rd_ready,
    output wire [WIDTH-1:0] rd_data,
    output wire [DEPTH_LOG2:0] count
);
    localparam DEPTH = 1 << DEPTH_LOG2;
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [DEPTH_LOG2-1:0] wp_r;
    reg [DEPTH_LOG2-1:0] rp_r;
    reg [DEPTH_LOG2:0] cnt_r;
    wire push;
    wire pop;

    assign wr_ready = (cnt_r != DEPTH[DEPTH_LOG2:0]);
    assign rd_valid = (cnt_r != {(DEPTH_LOG2+1){1'b0}});
    assign push = wr_valid & wr_ready;
    assign pop = rd_ready & rd_valid;
    assign rd_data = mem_r[rp_r];
    assign count = cnt_r;

    always @(posedge ref_clk) begin
        if (push) begin
            mem_r[wp_r] <= wr_data;
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wp_r <= {DEPTH_LOG2{1'b0}};
            rp_r <= {DEPTH_LOG2{1'b0}};
            cnt_r <= {(DEPTH_LOG2+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // word_fifo

// ### rtl/blit_host_path.v
// host-fed write blit and colour expansion engine with apb registers
`include "blit_defines.vh"

module blit_host_path #(
    parameter FIFO_LOG2 = 4
) (
    input wire ref_clk,
    input wire rstn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [20:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg mem_rd,
    output reg mem_wr,
    output reg [23:0] mem_addr,
    output reg [15:0] mem_wdata,
    output reg [1:0] mem_be,
    input wire [15:0] mem_rdata,
    input wire mem_rvalid
);
    // engine states; colour expand skips the destination read
    localparam ST_IDLE = 3'd0;
    localparam ST_POP = 3'd1;
    localparam ST_RD = 3'd2;
    localparam ST_RWAIT = 3'd3;
    localparam ST_WR = 3'd4;
    // occupancy thresholds behind the status flags
    localparam HALF = 1 << (FIFO_LOG2 - 1);
    localparam FULL = 1 << FIFO_LOG2;

    // setup registers
    reg [7:0] format_r;
    reg [7:0] rop_r;
    reg [7:0] opsel_r;
    reg [7:0] src_lo_r;
    reg [23:0] dst_r;
    reg [15:0] stride_r;
    reg [9:0] width_r;
    reg [9:0] height_r;
    reg [15:0] bg_r;
    reg [15:0] fg_r;
    reg [1:0] linear_r;

    // engine state
    reg [2:0] state_r;
    reg busy_r;
    reg [9:0] x_r;
    reg [9:0] y_r;
    reg [3:0] slot_r;
    reg first_r;
    reg [15:0] word_r;
    reg [15:0] dest_r;
    reg [23:0] addr_r;
    reg [23:0] line_r;
    reg not_empty_r;
    reg half_r;
    reg full_r;

    wire bus_access;
    wire bus_done;
    wire in_aperture;
    wire [8:0] idx;
    wire fifo_wr_valid;
    wire fifo_wr_ready;
    wire fifo_rd_valid;
    wire fifo_pop;
    wire [15:0] fifo_dout;
    wire [FIFO_LOG2:0] fifo_count;
    wire bpp16;
    wire expand;
    wire phase;
    wire [3:0] first_slot;
    wire [3:0] last_slot;
    wire [3:0] bit_sel;
    wire src_bit;
    wire [7:0] src_byte;
    wire [15:0] src_pix;
    wire [15:0] rop_res;
    wire [15:0] pix_out;
    wire [23:0] step;
    wire [23:0] line_nxt;
    wire [23:0] stride_bytes;
    reg [7:0] rd_byte;
    reg map_ok;

    assign bus_access = psel & penable & ~pready;
    assign bus_done = psel & penable & pready;
    assign in_aperture = paddr[`APERTURE_BIT];
    assign idx = paddr[10:2];

    // every accepted aperture word write counts once, whatever the host width
    assign fifo_wr_valid = bus_done & pwrite & in_aperture & ~pslverr;

    // host words queue here until the engine drains them
    word_fifo #(
        .WIDTH(16),
        .DEPTH_LOG2(FIFO_LOG2)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .wr_valid(fifo_wr_valid),
        .wr_ready(fifo_wr_ready),
        .wr_data(pwdata[15:0]),
        .rd_valid(fifo_rd_valid),
        .rd_ready(fifo_pop),
        .rd_data(fifo_dout),
        .count(fifo_count)
    );

    assign fifo_pop = (state_r == ST_POP) & fifo_rd_valid;

    // mode decode
    assign bpp16 = format_r[`FMT_16BPP_BIT];
    assign expand = (opsel_r == `OP_COLOR_EXPAND);
    assign phase = src_lo_r[0];
    // colour expand: slot 0..7 low byte bit 7..0, slot 8..15 high byte bit 7..0
    // start byte from source bit 0, start bit from the start position field
    assign first_slot = !first_r ? 4'h0 :
                        expand ? {phase, 3'h7 - rop_r[2:0]} :
                        (!bpp16 && phase) ? 4'h1 : 4'h0;
    assign last_slot = expand ? 4'hf : bpp16 ? 4'h0 : 4'h1;
    assign bit_sel = slot_r[3] ? (4'hf - {1'b0, slot_r[2:0]}) : (4'h7 - {1'b0, slot_r[2:0]});
    assign src_bit = word_r[bit_sel];
    // a slot of 0 always takes the low byte, so a lone last pixel comes from it
    assign src_byte = slot_r[0] ? word_r[15:8] : word_r[7:0];
    // expanded colour; 8 bpp uses only bits 7-0 of the colour
    assign src_pix = expand ? (bpp16 ? (src_bit ? fg_r : bg_r) :
                               (src_bit ? {fg_r[7:0], fg_r[7:0]} : {bg_r[7:0], bg_r[7:0]})) :
                     (bpp16 ? word_r : {src_byte, src_byte});

    // per-bit raster op: result = code[{source, destination}]
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_rop
            assign rop_res[gi] = rop_r[{src_pix[gi], dest_r[gi]}];
        end
    endgenerate
    assign pix_out = expand ? src_pix : rop_res;

    assign step = bpp16 ? 24'h000002 : 24'h000001;
    assign stride_bytes = {7'h00, stride_r, 1'b0};
    // linear mode packs lines back to back, rectangular advances by the stride
    assign line_nxt = linear_r[`LIN_DST_BIT] ? (addr_r + step) : (line_r + stride_bytes);

    // register read mux
    always @* begin
        rd_byte = 8'h00;
        map_ok = 1'b1;
        if (in_aperture) begin
            map_ok = pwrite;
        end else begin
            case (idx)
                `IDX_CTRL: rd_byte = {busy_r, not_empty_r, half_r, full_r, 4'h0};
                `IDX_FORMAT: rd_byte = format_r;
                `IDX_ROP: rd_byte = rop_r;
                `IDX_OPSEL: rd_byte = opsel_r;
                `IDX_SRC_LO: rd_byte = src_lo_r;
                `IDX_DST_LO: rd_byte = dst_r[7:0];
                `IDX_DST_MID: rd_byte = dst_r[15:8];
                `IDX_DST_HI: rd_byte = dst_r[23:16];
                `IDX_STRIDE_LO: rd_byte = stride_r[7:0];
                `IDX_STRIDE_HI: rd_byte = stride_r[15:8];
                `IDX_WIDTH_LO: rd_byte = width_r[7:0];
                `IDX_WIDTH_HI: rd_byte = {6'h00, width_r[9:8]};
                `IDX_HEIGHT_LO: rd_byte = height_r[7:0];
                `IDX_HEIGHT_HI: rd_byte = {6'h00, height_r[9:8]};
                `IDX_BG_LO: rd_byte = bg_r[7:0];
                `IDX_BG_HI: rd_byte = bg_r[15:8];
                `IDX_FG_LO: rd_byte = fg_r[7:0];
                `IDX_FG_HI: rd_byte = fg_r[15:8];
                `IDX_LINEAR: rd_byte = {6'h00, linear_r};
                default: map_ok = 1'b0;
            endcase
        end
    end

    // apb slave: one wait state, answer registered
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= bus_access;
            if (bus_access) begin
                prdata <= {24'h000000, rd_byte};
                // full fifo write is refused with an error, never queued
                pslverr <= ~map_ok | (in_aperture & ~fifo_wr_ready);
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // fifo flags follow occupancy every cycle
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            not_empty_r <= 1'b0;
            half_r <= 1'b0;
            full_r <= 1'b0;
        end else begin
            not_empty_r <= (fifo_count != {(FIFO_LOG2+1){1'b0}});
            half_r <= (fifo_count >= HALF[FIFO_LOG2:0]);
            full_r <= (fifo_count == FULL[FIFO_LOG2:0]);
        end
    end

    // setup register writes, taken in any order while idle or busy
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            format_r <= `RST_BYTE;
            rop_r <= `RST_ROP;
            opsel_r <= `RST_BYTE;
            src_lo_r <= `RST_BYTE;
            dst_r <= 24'h000000;
            stride_r <= 16'h0000;
            width_r <= 10'h000;
            height_r <= 10'h000;
            bg_r <= 16'h0000;
            fg_r <= 16'h0000;
            linear_r <= 2'b00;
        end else if (bus_done && pwrite && !in_aperture && !pslverr) begin
            case (idx)
                `IDX_FORMAT: format_r <= pwdata[7:0];
                `IDX_ROP: rop_r <= pwdata[7:0];
                `IDX_OPSEL: opsel_r <= pwdata[7:0];
                `IDX_SRC_LO: src_lo_r <= pwdata[7:0];
                `IDX_DST_LO: dst_r[7:0] <= pwdata[7:0];
                `IDX_DST_MID: dst_r[15:8] <= pwdata[7:0];
                `IDX_DST_HI: dst_r[23:16] <= pwdata[7:0];
                `IDX_STRIDE_LO: stride_r[7:0] <= pwdata[7:0];
                `IDX_STRIDE_HI: stride_r[15:8] <= pwdata[7:0];
                `IDX_WIDTH_LO: width_r[7:0] <= pwdata[7:0];
                `IDX_WIDTH_HI: width_r[9:8] <= pwdata[1:0];
                `IDX_HEIGHT_LO: height_r[7:0] <= pwdata[7:0];
                `IDX_HEIGHT_HI: height_r[9:8] <= pwdata[1:0];
                `IDX_BG_LO: bg_r[7:0] <= pwdata[7:0];
                `IDX_BG_HI: bg_r[15:8] <= pwdata[7:0];
                `IDX_FG_LO: fg_r[7:0] <= pwdata[7:0];
                `IDX_FG_HI: fg_r[15:8] <= pwdata[7:0];
                `IDX_LINEAR: linear_r <= pwdata[1:0];
                default: linear_r <= linear_r;
            endcase
        end
    end

    // pixel engine: pops words, walks pixels, optional destination read, writes
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            x_r <= 10'h000;
            y_r <= 10'h000;
            slot_r <= 4'h0;
            first_r <= 1'b0;
            word_r <= 16'h0000;
            dest_r <= 16'h0000;
            addr_r <= 24'h000000;
            line_r <= 24'h000000;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= 24'h000000;
            mem_wdata <= 16'h0000;
            mem_be <= 2'b00;
        end else begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    // start only for the two supported operations
                    if (bus_done && pwrite && !in_aperture && idx == `IDX_CTRL &&
                        pwdata[`CTRL_START_BIT] &&
                        (opsel_r == `OP_WRITE_ROP || opsel_r == `OP_COLOR_EXPAND)) begin
                        busy_r <= 1'b1;
                        x_r <= 10'h000;
                        y_r <= 10'h000;
                        first_r <= 1'b1;
                        addr_r <= dst_r;
                        line_r <= dst_r;
                        state_r <= ST_POP;
                    end
                end
                ST_POP: begin
                    // stalls here while the host has not supplied a word
                    if (fifo_rd_valid) begin
                        word_r <= fifo_dout;
                        slot_r <= first_slot;
                        first_r <= 1'b0;
                        state_r <= expand ? ST_WR : ST_RD;
                    end
                end
                ST_RD: begin
                    // destination word fetched for the raster op
                    mem_rd <= 1'b1;
                    mem_addr <= {addr_r[23:1], 1'b0};
                    state_r <= ST_RWAIT;
                end
                ST_RWAIT: begin
                    // no timeout: the buffer may stall for any time
                    if (mem_rvalid) begin
                        dest_r <= mem_rdata;
                        state_r <= ST_WR;
                    end
                end
                ST_WR: begin
                    mem_wr <= 1'b1;
                    mem_addr <= {addr_r[23:1], 1'b0};
                    mem_wdata <= pix_out;
                    mem_be <= bpp16 ? 2'b11 : (addr_r[0] ? 2'b10 : 2'b01);
                    if (x_r == width_r) begin
                        // end of line; remaining bits of the word are dropped
                        x_r <= 10'h000;
                        if (y_r == height_r) begin
                            busy_r <= 1'b0;
                            state_r <= ST_IDLE;
                        end else begin
                            y_r <= y_r + 10'h001;
                            line_r <= line_nxt;
                            addr_r <= line_nxt;
                            first_r <= 1'b1;
                            state_r <= ST_POP;
                        end
                    end else begin
                        x_r <= x_r + 10'h001;
                        addr_r <= addr_r + step;
                        if (slot_r == last_slot) begin
                            state_r <= ST_POP;
                        end else begin
                            slot_r <= slot_r + 4'h1;
                            state_r <= expand ? ST_WR : ST_RD;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // blit_host_path

// ### verification/blit_host_path_sva.sv
// protocol checker for the host-fed blit data path ports
module blit_host_path_sva #(
    parameter FIFO_LOG2 = 4
) (
    input logic ref_clk,
    input logic rstn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [20:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic mem_rd,
    input logic mem_wr,
    input logic [23:0] mem_addr,
    input logic [15:0] mem_wdata,
    input logic [1:0] mem_be,
    input logic [15:0] mem_rdata,
    input logic mem_rvalid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_setup;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_read_back;
        mem_rvalid ##[1:3] mem_wr;
    endsequence
    property p_one_wait;
        s_setup |-> !pready ##1 pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
    property p_aperture_read;
        pready && !pwrite && paddr[20] |-> pslverr && prdata == 32'h0;
    endproperty
    a_aperture_read: assert property (p_aperture_read) else $error("aperture read accepted");
    property p_rdata_byte;
        pready && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    a_rdata_byte: assert property (p_rdata_byte) else $error("upper read data not zero");
    property p_strobe_gap;
        mem_rd |-> !mem_wr ##1 !mem_rd && !mem_wr;
    endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("buffer strobe right after a read request");
    property p_aligned;
        mem_rd || mem_wr |-> !mem_addr[0] && (!mem_wr || mem_be != 2'b00);
    endproperty
    a_aligned: assert property (p_aligned) else $error("bad buffer address or enables");
    property p_read_back;
        mem_rvalid |-> s_read_back;
    endproperty
    a_read_back: assert property (p_read_back) else $error("no write after read data");
endmodule // blit_host_path_sva

// ### verification/disp_buf_model.sv
// display buffer model answering the engine's strobes
module disp_buf_model (
    input logic ref_clk,
    input logic mem_rd,
    input logic mem_wr,
    input logic [23:0] mem_addr,
    input logic [15:0] mem_wdata,
    input logic [1:0] mem_be,
    output logic [15:0] mem_rdata,
    output logic mem_rvalid,
    input logic slow
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:511];
    logic [8:0] ra;
    int wait_n;
    initial begin
        for (int i = 0; i < 512; i++) mem[i] = 16'ha5c3 ^ 16'(i);
        mem_rvalid = 1'b0;
        mem_rdata = 16'h0;
        wait_n = -1;
    end
    always @(posedge ref_clk) begin
        mem_rvalid <= 1'b0;
        // data line is not held outside a valid beat
        mem_rdata <= ~mem_rdata;
        if (mem_wr && mem_be[0]) mem[mem_addr[9:1]][7:0] <= mem_wdata[7:0];
        if (mem_wr && mem_be[1]) mem[mem_addr[9:1]][15:8] <= mem_wdata[15:8];
        if (mem_rd) begin
            ra <= mem_addr[9:1];
            wait_n <= slow ? 200 : 1;
        end else if (wait_n > 0) begin
            wait_n <= wait_n - 1;
        end else if (wait_n == 0) begin
            mem_rvalid <= 1'b1;
            mem_rdata <= mem[ra];
            wait_n <= -1;
        end
    end
endmodule // disp_buf_model

// ### verification/tb_top.sv
// self-checking bench for the host-fed blit data path
`include "blit_defines.vh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic slow = 1'b0;
    logic [20:0] paddr = 21'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, mem_rd, mem_wr, mem_rvalid, err;
    logic [23:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata, s, ew;
    logic [1:0] mem_be;
    logic [7:0] px [0:15];
    int n_fail = 0;
    int n_checks = 0;
    int q;

    always #2.5 ref_clk = ~ref_clk;

    blit_host_path #(.FIFO_LOG2(4)) blit_host_path_inst (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_be(mem_be), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
    disp_buf_model disp_buf_model_inst (.ref_clk(ref_clk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .slow(slow));

    task automatic conclude;
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [20:0] a, input logic [31:0] d);
        int t;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge ref_clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input int i, input int v);
        apb(1'b1, {10'h0, i[8:0], 2'b00}, {24'h0, v[7:0]});
    endtask

    task automatic rdreg(input int i);
        apb(1'b0, {10'h0, i[8:0], 2'b00}, 32'h0);
    endtask

    task automatic put(input logic [15:0] v);
        apb(1'b1, 21'h100000, {16'h0, v});
    endtask

    task automatic poll(input int b);
        int t;
        t = 0;
        do begin
            rdreg(`IDX_CTRL);
            t++;
        end while (rd[b] !== 1'b0 && t < 2000);
        if (rd[b] !== 1'b0) n_fail++;
    endtask

    task automatic wait_done;
        poll(`CTRL_START_BIT);
        chk(rd & 32'hf0, 32'h0);
    endtask

    task automatic wchk(input int i, input logic [15:0] exp);
        chk({16'h0, disp_buf_model_inst.mem[i]}, {16'h0, exp});
    endtask

    task automatic setup(input int fmt, raster_operation, op, src, lin, dst, stride, w, h);
        wr(`IDX_WIDTH_LO, w);
        wr(`IDX_WIDTH_HI, w >> 8);
        wr(`IDX_HEIGHT_LO, h);
        wr(`IDX_HEIGHT_HI, h >> 8);
        wr(`IDX_DST_LO, dst);
        wr(`IDX_DST_MID, dst >> 8);
        wr(`IDX_DST_HI, 0);
        wr(`IDX_STRIDE_LO, stride);
        wr(`IDX_STRIDE_HI, stride >> 8);
        wr(`IDX_LINEAR, lin);
        wr(`IDX_SRC_LO, src);
        wr(`IDX_ROP, raster_operation);
        wr(`IDX_FORMAT, fmt);
        wr(`IDX_OPSEL, op);
        wr(`IDX_CTRL, 8'h80);
        rdreg(`IDX_CTRL);
        chk(rd & 32'h80, 32'h80);
    endtask

    function automatic logic [15:0] raster_f(input logic [3:0] c, input logic [15:0] sv, input logic [15:0] dv);
        for (int b = 0; b < 16; b++) raster_f[b] = c[{sv[b], dv[b]}];
    endfunction

    initial begin
        #200000;
        n_fail++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        rdreg(`IDX_CTRL);
        chk(rd, 32'h0);
        rdreg(`IDX_ROP);
        chk(rd, 32'h0c);
        rdreg(9'h1ff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 21'h100000, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(`IDX_OPSEL, 8'h0c);
        wr(`IDX_CTRL, 8'h80);
        rdreg(`IDX_CTRL);
        chk(rd, 32'h0);
        for (int c = 0; c < 16; c++) begin
            setup(1, c, `OP_WRITE_ROP, 0, 0, 16'h40 + 2 * c, 0, 0, 0);
            put(16'h3c96);
            wait_done();
            wchk(16'h20 + c, raster_f(c[3:0], 16'h3c96, 16'ha5c3 ^ 16'(16'h20 + c)));
        end
        for (int lin = 0; lin < 2; lin++) begin
            setup(1, 8'h0c, 0, 0, lin, 16'h100, 8, 1, 1);
            for (int k = 0; k < 4; k++) put(16'h1000 + 16'(16 * lin + k));
            wait_done();
            for (int k = 0; k < 4; k++) begin
                q = 16'h80 + k % 2 + (k / 2) * (lin ? 2 : 8);
                wchk(q, 16'h1000 + 16'(16 * lin + k));
            end
        end
        for (int ph = 0; ph < 2; ph++) begin
            setup(0, 8'h0c, 0, ph, 0, 16'h200 + 16'h100 * ph, 16, 2, 1);
            for (int l = 0; l < 2; l++) begin
                put(ph ? {8'h10 + 8'(l), 8'hee} : {8'h20 + 8'(l), 8'h10 + 8'(l)});
                put(ph ? {8'h30 + 8'(l), 8'h20 + 8'(l)} : {8'hee, 8'h30 + 8'(l)});
            end
            wait_done();
            for (int l = 0; l < 2; l++) begin
                ew = 16'ha5c3 ^ 16'(16'h101 + 16'h80 * ph + 16 * l);
                wchk(16'h100 + 16'h80 * ph + 16 * l, {8'h20 + 8'(l), 8'h10 + 8'(l)});
                wchk(16'h101 + 16'h80 * ph + 16 * l, {ew[15:8], 8'h30 + 8'(l)});
            end
        end
        wr(`IDX_FG_LO, 8'h86);
        wr(`IDX_FG_HI, 8'h12);
        wr(`IDX_BG_LO, 8'h7c);
        s = 16'hb4c5;
        for (int e = 0; e < 2; e++) begin
            setup(0, e ? 1 : 7, `OP_COLOR_EXPAND, e, 0, 16'h380, 0, e ? 1 : 15, 0);
            put(s);
            wait_done();
            for (int k = 0; k < (e ? 2 : 16); k++) begin
                q = (e ? 14 : 0) + k;
                px[k] = s[q < 8 ? 7 - q : 23 - q] ? 8'h86 : 8'h7c;
            end
            for (int j = 0; j < (e ? 1 : 8); j++) wchk(16'h1c0 + j, {px[2 * j + 1], px[2 * j]});
        end
        setup(1, 7, `OP_COLOR_EXPAND, 0, 0, 16'h3a0, 0, 3, 0);
        put(s);
        wait_done();
        for (int k = 0; k < 4; k++) wchk(16'h1d0 + k, s[7 - k] ? 16'h1286 : 16'h007c);
        slow <= 1'b1;
        setup(1, 8'h0c, 0, 0, 1, 0, 0, 17, 0);
        for (int k = 0; k < 17; k++) put(16'h2000 + 16'(k));
        rdreg(`IDX_CTRL);
        chk(rd & 32'hf0, 32'hf0);
        put(16'h2011);
        chk({31'h0, err}, 32'h1);
        poll(`CTRL_FULL_BIT);
        put(16'h2011);
        chk({31'h0, err}, 32'h0);
        wait_done();
        for (int k = 0; k < 18; k++) wchk(k, 16'h2000 + 16'(k));
        conclude();
    end
endmodule // tb_top

bind blit_host_path blit_host_path_sva #(.FIFO_LOG2(FIFO_LOG2)) blit_host_path_sva_inst (.ref_clk(ref_clk),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
